// File: logic/rx_queue_host_readout.sv
`timescale 1ns/1ps
module rx_queue_host_readout
  import rxq_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic [9:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        byte_mode_i,
  input  wire logic        mac_wr_i,
  input  wire logic [15:0] mac_wdata_i,
  input  wire logic        mac_frame_done_i,
  output logic [15:0]      rdata_o,
  output logic             irq_o,
  output logic             mac_ready_o
);
  rxq_mem_if mem ();

  rxq_store u_store (
    .ref_clk_i (ref_clk_i),
    .port      (mem.mem)
  );

  logic [15:0]        irq_status_reg;
  logic [15:0]        irq_enable_reg;
  logic [15:0]        rx_queue_control_reg;
  logic [15:0]        rx_header_status_reg;
  logic [LENGTH_W-1:0] rx_header_length_reg;
  logic [7:0]         rx_frame_tally;
  logic [7:0]         frames_stored;
  logic [QADDR_W-1:0] wr_ptr;
  logic [QADDR_W-1:0] frame_start;
  logic [QADDR_W-1:0] rd_ptr;
  logic [QADDR_W-1:0] next_rd_ptr;
  logic [QADDR_W-1:0] cur_start;
  logic               status_seen;
  logic               length_seen;
  logic               burst_first;
  logic               byte_half;
  logic               hdr_pending;

  typedef enum {IDLE, HDR_ADDR, HDR_STATUS, HDR_LENGTH} hdr_state_t;
  hdr_state_t hdr_state;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
    return a[9:1] == off[9:1];
  endfunction : hit

  wire wr_clr_rx    = wr_i && hit(addr_i, OFF_IRQ_STATUS) && wdata_i[RX_IRQ_BIT];
  wire rd_tally     = rd_i && hit(addr_i, OFF_FRAME_TALLY);
  wire rd_status    = rd_i && hit(addr_i, OFF_HDR_STATUS);
  wire rd_length    = rd_i && hit(addr_i, OFF_HDR_LENGTH);
  wire rd_data_port = rd_i && hit(addr_i, OFF_DATA_PORT);
  wire start_access = rx_queue_control_reg[START_ACCESS_BIT];
  wire both_seen    = (status_seen || rd_status) && (length_seen || rd_length);
  wire frame_in     = mac_wr_i && mac_frame_done_i;

  // storage writes from the receive side; full stops the mac
  assign mem.wr_en   = mac_wr_i && mac_ready_o;
  assign mem.wr_addr = wr_ptr;
  assign mem.wr_data = mac_wdata_i;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_ptr      <= '0;
      mac_ready_o <= 1'b0;
    end else begin
      if (mem.wr_en) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      // ready drops only while wr_ptr is two words short of cur_start; a late write lets it pass
      // the guard sits at the frame under readout (cur_start), not just the next one
      mac_ready_o <= (wr_ptr + QADDR_W'(2)) != cur_start;
    end
  end

  // frames waiting in the queue
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      frames_stored <= '0;
    end else if (frame_in && mac_ready_o && !(hdr_state == HDR_LENGTH && frames_stored != 0)) begin
      frames_stored <= frames_stored + 1'b1;
    end else if (!(frame_in && mac_ready_o) && hdr_state == HDR_LENGTH && frames_stored != 0) begin
      frames_stored <= frames_stored - 1'b1;
    end
  end

  // interrupt status, set wins over clear
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_status_reg <= '0;
    end else begin
      if (wr_i && hit(addr_i, OFF_IRQ_STATUS)) begin
        irq_status_reg <= irq_status_reg & ~wdata_i;
      end
      if (frame_in && mac_ready_o) begin
        irq_status_reg[RX_IRQ_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_reg & irq_enable_reg);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_enable_reg       <= IRQ_ENABLE_RST;
      rx_queue_control_reg <= QUEUE_CTRL_RST;
    end else if (wr_i) begin
      if (hit(addr_i, OFF_IRQ_ENABLE)) begin
        irq_enable_reg <= wdata_i;
      end
      if (hit(addr_i, OFF_QUEUE_CTRL)) begin
        rx_queue_control_reg <= wdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rx_frame_tally <= '0;
    end else if (wr_clr_rx) begin
      rx_frame_tally <= frames_stored;
    end
  end

  // header fetch sequencer
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      hdr_state            <= IDLE;
      hdr_pending          <= 1'b0;
      status_seen          <= 1'b0;
      length_seen          <= 1'b0;
      rx_header_status_reg <= '0;
      rx_header_length_reg <= '0;
      frame_start          <= '0;
      cur_start            <= '0;
    end else begin
      if (rd_status) begin
        status_seen <= 1'b1;
      end
      if (rd_length) begin
        length_seen <= 1'b1;
      end
      case (hdr_state)
        IDLE: begin
          // waits out a burst: the store port is shared with data reads
          if (hdr_pending && frames_stored != 0 && !start_access) begin
            hdr_pending <= 1'b0;
            hdr_state   <= HDR_ADDR;
          end
        end
        HDR_ADDR: begin
          hdr_state <= HDR_STATUS;
        end
        HDR_STATUS: begin
          rx_header_status_reg <= mem.rd_data;
          hdr_state            <= HDR_LENGTH;
        end
        HDR_LENGTH: begin
          rx_header_length_reg <= mem.rd_data[LENGTH_W-1:0];
          frame_start <= frame_start + QADDR_W'(HDR_WORDS)
                         + QADDR_W'((mem.rd_data[LENGTH_W-1:0] + 12'h003) >> 1) & ~QADDR_W'(1);
          cur_start   <= frame_start;
          hdr_state   <= IDLE;
        end
        default: hdr_state <= IDLE;
      endcase
      // tally read or both header reads
      if (rd_tally || (both_seen && (rd_status || rd_length))) begin
        hdr_pending <= 1'b1;
        status_seen <= 1'b0;
        length_seen <= 1'b0;
      end
    end
  end

  // data burst pointer: dummy first, bytes paired in 8-bit mode
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rd_ptr      <= '0;
      burst_first <= 1'b1;
      byte_half   <= 1'b0;
    end else if (!start_access) begin
      burst_first <= 1'b1;
      byte_half   <= 1'b0;
      rd_ptr      <= next_rd_ptr;
    end else if (rd_data_port) begin
      if (burst_first) begin
        burst_first <= 1'b0;
      end else if (byte_mode_i && !byte_half) begin
        byte_half <= 1'b1;
      end else begin
        byte_half <= 1'b0;
        rd_ptr    <= next_rd_ptr;
      end
    end
  end

  // look one word ahead so the registered store holds the datum at the strobe
  always_comb begin
    next_rd_ptr = rd_ptr;
    if (!start_access) begin
      next_rd_ptr = cur_start + QADDR_W'(HDR_WORDS);
    end else if (rd_data_port && !burst_first && !(byte_mode_i && !byte_half)) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  assign mem.rd_addr = (hdr_state == HDR_ADDR) ? frame_start :
                       (hdr_state == HDR_STATUS) ? frame_start + 1'b1 : next_rd_ptr;

  // read data from a flop, standing the cycle after the strobe only
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (rd_data_port && start_access && !burst_first) begin
      if (!byte_mode_i) begin
        rdata_o <= mem.rd_data;
      end else if (byte_half) begin
        rdata_o <= {8'h00, mem.rd_data[15:8]};
      end else begin
        rdata_o <= {8'h00, mem.rd_data[7:0]};
      end
    end else if (rd_data_port) begin
      rdata_o <= DUMMY_DATUM;
    end else if (rd_i) begin
      case (1'b1)
        hit(addr_i, OFF_HDR_STATUS):  rdata_o <= rx_header_status_reg;
        hit(addr_i, OFF_HDR_LENGTH):  rdata_o <= {4'h0, rx_header_length_reg};
        hit(addr_i, OFF_QUEUE_CTRL):  rdata_o <= rx_queue_control_reg;
        hit(addr_i, OFF_IRQ_ENABLE):  rdata_o <= irq_enable_reg;
        hit(addr_i, OFF_IRQ_STATUS):  rdata_o <= irq_status_reg;
        hit(addr_i, OFF_FRAME_TALLY): rdata_o <= {rx_frame_tally, 8'h00};
        default:                      rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
endmodule : rx_queue_host_readout

// File: pkg/rxq_pkg.sv
package rxq_pkg;
  // register byte offsets on the host port
  localparam logic [9:0] OFF_HDR_STATUS = 10'h17C;
  localparam logic [9:0] OFF_HDR_LENGTH = 10'h17E;
  localparam logic [9:0] OFF_QUEUE_CTRL = 10'h182;
  localparam logic [9:0] OFF_DATA_PORT  = 10'h184;
  localparam logic [9:0] OFF_IRQ_ENABLE = 10'h190;
  localparam logic [9:0] OFF_IRQ_STATUS = 10'h192;
  localparam logic [9:0] OFF_FRAME_TALLY = 10'h1B8;
  // field positions and widths
  localparam int RX_IRQ_BIT      = 13;
  localparam int START_ACCESS_BIT = 3;
  localparam int TALLY_LSB       = 8;
  localparam int LENGTH_W        = 12;
  // reset values and the dummy datum
  localparam logic [15:0] IRQ_ENABLE_RST = 16'h0000;
  localparam logic [15:0] QUEUE_CTRL_RST = 16'h0000;
  localparam logic [15:0] DUMMY_DATUM    = 16'h0000;
  // queue geometry: 16-bit words, header is two words
  localparam int QWORDS  = 1024;
  localparam int QADDR_W = 10;
  localparam int HDR_WORDS = 2;
endpackage : rxq_pkg

// File: pkg/rxq_mem_if.sv
`timescale 1ns/1ps
interface rxq_mem_if;
  logic [9:0]  rd_addr;
  logic [15:0] rd_data;
  logic [9:0]  wr_addr;
  logic [15:0] wr_data;
  logic        wr_en;
  modport ctrl (output rd_addr, input rd_data, output wr_addr, output wr_data, output wr_en);
  modport mem  (input rd_addr, output rd_data, input wr_addr, input wr_data, input wr_en);
endinterface : rxq_mem_if

// File: logic/rxq_store.sv
`timescale 1ns/1ps
module rxq_store
  import rxq_pkg::*;
(
  input  wire logic ref_clk_i,
  rxq_mem_if.mem    port
);
  logic [15:0] words [QWORDS];

  // registered read: one cycle latency
  always_ff @(posedge ref_clk_i) begin
    if (port.wr_en) begin
      words[port.wr_addr] <= port.wr_data;
    end
    port.rd_data <= words[port.rd_addr];
  end
endmodule : rxq_store

// File: verif/rxq_assertions.sv
`timescale 1ns/1ps
module rxq_assertions
  import rxq_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic [9:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        byte_mode_i,
  input  wire logic [15:0] rdata_o,
  input  wire logic        irq_o,
  input  wire logic        mac_ready_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  wire         rd_len = rd_i && addr_i[9:1] == OFF_HDR_LENGTH[9:1];
  wire         rd_tal = rd_i && addr_i[9:1] == OFF_FRAME_TALLY[9:1];
  wire         rd_dat = rd_i && addr_i[9:1] == OFF_DATA_PORT[9:1];
  logic [15:0] en_q;
  logic        armed;
  // shadow of the enable mask, so irq can be tied to it
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) en_q <= IRQ_ENABLE_RST;
    else if (wr_i && addr_i[9:1] == OFF_IRQ_ENABLE[9:1]) en_q <= wdata_i;
  end
  // a repeated set rearms here, though the dut keeps burst_first clear until start_access falls
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) armed <= 1'b0;
    else if (wr_i && addr_i[9:1] == OFF_QUEUE_CTRL[9:1]) armed <= wdata_i[START_ACCESS_BIT];
    else if (rd_dat) armed <= 1'b0;
  end
  sequence s_first_rd;
    armed && rd_dat;
  endsequence
  a_reset_quiet:
    assert property (disable iff (1'b0) srst_i |=> !irq_o && !mac_ready_o) else $error("busy in reset");
  a_irq_after_rel: assert property ($fell(srst_i) |-> !irq_o [*2]) else $error("early irq");
  a_irq_needs_en: assert property (irq_o |-> $past(en_q) != 16'h0000) else $error("irq unmasked");
  a_length_width: assert property (rd_len |=> rdata_o[15:12] == 4'h0) else $error("length wide");
  a_tally_upper: assert property (rd_tal |=> rdata_o[7:0] == 8'h00) else $error("tally low byte");
  a_dummy_first: assert property (s_first_rd |=> rdata_o == DUMMY_DATUM) else $error("no dummy");
  a_byte_lane:
    assert property (byte_mode_i && rd_dat |=> rdata_o[15:8] == 8'h00) else $error("byte lane");
  a_unmapped_zero:
    assert property (rd_i && addr_i == 10'h000 |=> rdata_o == 16'h0000) else $error("unmapped");
endmodule : rxq_assertions
bind rx_queue_host_readout rxq_assertions u_chk (.ref_clk_i, .srst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .byte_mode_i, .rdata_o, .irq_o, .mac_ready_o);

// File: verif/mac_feed.sv
`timescale 1ns/1ps
module mac_feed (
  input  wire logic   ref_clk_i,
  output logic        wr_o,
  output logic [15:0] wdata_o,
  output logic        done_o
);
  initial wr_o = 1'b0;
  initial wdata_o = 16'h0000;
  initial done_o = 1'b0;
  // data area padded to double word
  task automatic send_frame(input logic [15:0] st, input logic [15:0] len, input logic [7:0] tg);
    int n;
    n = 2 + ((len[11:0] + 3) / 4) * 2;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_i);
      wr_o <= 1'b1;
      wdata_o <= (i == 0) ? st : (i == 1) ? len : {tg, 8'(i - 2)};
      done_o <= (i == n - 1);
    end
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    done_o <= 1'b0;
  endtask : send_frame
endmodule : mac_feed

// File: verif/rx_queue_host_readout_tb.sv
`timescale 1ns/1ps
module rx_queue_host_readout_tb;
  import rxq_pkg::*;
  logic        ref_clk_i   = 1'b0;
  logic        srst_i      = 1'b1;
  logic [9:0]  addr_i      = 10'h000;
  logic [15:0] wdata_i     = 16'h0000;
  logic        wr_i        = 1'b0;
  logic        rd_i        = 1'b0;
  logic        byte_mode_i = 1'b0;
  logic        mac_wr_i, mac_frame_done_i, irq_o, mac_ready_o;
  logic [15:0] mac_wdata_i, rdata_o, d;
  int          fail_count  = 0;
  int          cmp_count   = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  rx_queue_host_readout dut (.ref_clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .byte_mode_i,
    .mac_wr_i, .mac_wdata_i, .mac_frame_done_i, .rdata_o, .irq_o, .mac_ready_o);
  mac_feed feed (.ref_clk_i, .wr_o(mac_wr_i), .wdata_o(mac_wdata_i), .done_o(mac_frame_done_i));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [15:0] v);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task automatic waitchk(input string what, input logic exp);
    repeat (2) @(posedge ref_clk_i);
    #1 chk(what, 16'(exp), 16'(irq_o));
  endtask : waitchk
  // n reads past the dummy: length rounded to four bytes
  task automatic burst(input int n, input logic [7:0] tg, input logic bm);
    logic [15:0] e;
    wr(OFF_QUEUE_CTRL, 16'h0008);
    rd(OFF_DATA_PORT, d);
    chk("dummy", DUMMY_DATUM, d);
    for (int i = 0; i < n; i++) begin
      rd(OFF_DATA_PORT, d);
      e = bm ? {8'h00, i[0] ? tg : 8'(i / 2)} : {tg, 8'(i)};
      chk("data", e, d);
    end
    wr(OFF_QUEUE_CTRL, 16'h0000);
  endtask : burst
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    fail_count++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    wr(OFF_IRQ_ENABLE, 16'h2000);
    chk("ready", 16'h0001, 16'(mac_ready_o));
    feed.send_frame(16'h8001, 16'h0005, 8'h11);
    feed.send_frame(16'h8002, 16'hF004, 8'h22);
    waitchk("irq set", 1'b1);
    wr(OFF_IRQ_ENABLE, 16'h0000);
    waitchk("irq masked", 1'b0);
    wr(OFF_IRQ_ENABLE, 16'h2000);
    waitchk("irq unmasked", 1'b1);
    wr(OFF_IRQ_STATUS, 16'h2000);
    waitchk("irq cleared", 1'b0);
    rd(OFF_FRAME_TALLY, d);
    chk("tally", 16'h0200, d);
    repeat (4) @(posedge ref_clk_i);
    rd(OFF_HDR_STATUS, d);
    chk("status a", 16'h8001, d);
    burst(4, 8'h11, 1'b0);
    rd(OFF_HDR_LENGTH, d);
    chk("length a", 16'h0005, d);
    repeat (4) @(posedge ref_clk_i);
    rd(OFF_HDR_STATUS, d);
    chk("status b", 16'h8002, d);
    rd(OFF_HDR_LENGTH, d);
    chk("length b", 16'h0004, d);
    @(posedge ref_clk_i);
    byte_mode_i <= 1'b1;
    burst(4, 8'h22, 1'b1);
    rd(10'h000, d);
    chk("unmapped", 16'h0000, d);
    give_verdict;
  end
endmodule : rx_queue_host_readout_tb
